// ==== pbo_far_model.sv ====
// pbo_far_model: behavioural timer, serial and clock-system sources for the override block.
// assumes sys_clk is shared; every output changes just after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module pbo_far_model (
  input wire logic sys_clk, // i/o clock
  input wire logic slow, // 1 = compare a waveform moves at a quarter rate
  output logic wave_a, // compare a waveform
  output logic wave_b, // compare b waveform
  output logic div_clk, // divided system clock
  output logic shift_out, // serial data out
  output logic clk_hold // serial clock hold
);
  // ****
  // free-running sources
  // ****
  // no reset: the divided clock must keep running while the device is held in reset
  logic [7:0] cnt_q = 8'h00;

  always @(posedge sys_clk) begin
    cnt_q <= cnt_q + 8'h01;
  end

  assign div_clk = cnt_q[0];
  assign wave_a = slow ? cnt_q[3] : cnt_q[1];
  assign wave_b = cnt_q[2] ^ cnt_q[0];
  assign shift_out = cnt_q[4] ^ cnt_q[1];
  assign clk_hold = cnt_q[2];
endmodule

`default_nettype wire

// ==== pbo_override.sv ====
// pbo_override: port b pins 6..0 override merge and alternate-function taps.
// assumes port registers, timer, serial and clock logic live outside and
// share sys_clk; pad inputs are already synchronous to it.
`timescale 1ns/10ps
`default_nettype none

module pbo_override (
  input wire logic sys_clk, // i/o clock, 125 mhz
  input wire logic reset, // synchronous, active high
  input wire pbo_pkg::pbo_ctrl_s ctrl, // peripheral and fuse controls
  input wire logic [6:0] port_value_reg, // port value bits 6..0
  input wire logic [6:0] direction_reg, // direction bits 6..0
  input wire logic [6:0] pad_in, // pad levels
  output pbo_pkg::pbo_pad_s pad, // resolved pad drive
  output pbo_pkg::pbo_read_s readback, // software-visible bits
  output logic external_interrupt_zero, // external interrupt input level
  output logic [6:0] pin_change_source, // sources 14..8
  output logic serial_clock_in, // serial clock input level
  output logic serial_data_in // serial data input level
);

  // ****************************************************************
  // override terms
  // ****************************************************************
  logic [6:0] pu_oe;
  logic [6:0] pu_ov;
  logic [6:0] dd_oe;
  logic [6:0] dd_ov;
  logic [6:0] pv_oe;
  logic [6:0] pv_ov;
  logic [6:0] die_oe;
  logic [6:0] die_ov;
  logic [6:0] tg_oe;
  logic [6:0] pc_en;
  logic [6:0] cmp_en;
  logic two_def;
  logic three_def;
  logic clk_out_on;
  logic osc_one;
  logic osc_two;

  always_comb begin
    two_def = ctrl.serial_two_wire_mode & ctrl.serial_pin_position_select;
    three_def = ctrl.serial_three_wire_mode & ctrl.serial_pin_position_select;
    clk_out_on = ctrl.clock_output_fuse;
    osc_one = ctrl.oscillator_pin_one_used;
    osc_two = ctrl.oscillator_pin_two_used & ~clk_out_on;
    pc_en = {7{ctrl.pin_change_group_enable}} & ctrl.pin_change_mask;
    cmp_en = ctrl.timer1_output_select_control & ((pbo_pkg::COMPARE_A_PINS &
             {7{ctrl.compare_a_output_enable}}) | (~pbo_pkg::COMPARE_A_PINS &
             {7{ctrl.compare_b_output_enable}}));
    pu_oe = '0;
    pu_ov = '0;
    dd_oe = '0;
    dd_ov = '0;
    tg_oe = '0;
    pv_oe = cmp_en;
    for (int i = 0; i < pbo_pkg::NUM_PINS; i++) begin
      pv_ov[i] = pbo_pkg::COMPARE_A_PINS[i] ? ctrl.compare_a_wave : ctrl.compare_b_wave;
    end
    die_oe = pc_en;
    die_ov = pc_en;
    die_oe[pbo_pkg::PIN_EXT_INT] = ctrl.analog_input_disable[1] |
        ctrl.external_interrupt_zero_enable | pc_en[pbo_pkg::PIN_EXT_INT];
    die_ov[pbo_pkg::PIN_EXT_INT] = ctrl.external_interrupt_zero_enable |
        pc_en[pbo_pkg::PIN_EXT_INT];
    die_oe[pbo_pkg::PIN_CLK_OUT] = ctrl.analog_input_disable[0] | pc_en[pbo_pkg::PIN_CLK_OUT];
    die_ov[pbo_pkg::PIN_OSC_ONE] = 1'b1;
    die_ov[3] = 1'b1;
    die_ov[pbo_pkg::PIN_SER_DOUT] = 1'b1;
    // two-wire open-drain on pins 2 and 0
    dd_oe[pbo_pkg::PIN_SER_CLK] = two_def;
    dd_ov[pbo_pkg::PIN_SER_CLK] = (ctrl.serial_clock_hold |
        port_value_reg[pbo_pkg::PIN_SER_CLK]) & direction_reg[pbo_pkg::PIN_SER_CLK];
    dd_oe[pbo_pkg::PIN_SER_DATA] = two_def;
    dd_ov[pbo_pkg::PIN_SER_DATA] = (ctrl.serial_shift_out |
        port_value_reg[pbo_pkg::PIN_SER_DATA]) & direction_reg[pbo_pkg::PIN_SER_DATA];
    if (two_def & direction_reg[pbo_pkg::PIN_SER_CLK]) begin
      pv_oe[pbo_pkg::PIN_SER_CLK] = 1'b1;
      pv_ov[pbo_pkg::PIN_SER_CLK] = 1'b0;
    end
    if (two_def & direction_reg[pbo_pkg::PIN_SER_DATA]) begin
      pv_oe[pbo_pkg::PIN_SER_DATA] = 1'b1;
      pv_ov[pbo_pkg::PIN_SER_DATA] = 1'b0;
    end
    // toggle, serial input enables, shift-out priority
    tg_oe[pbo_pkg::PIN_SER_CLK] = ctrl.serial_toggle_override & ctrl.serial_pin_position_select;
    die_oe[pbo_pkg::PIN_SER_CLK] = (ctrl.serial_start_interrupt_enable &
        ctrl.serial_pin_position_select) | pc_en[pbo_pkg::PIN_SER_CLK];
    die_ov[pbo_pkg::PIN_SER_CLK] = die_oe[pbo_pkg::PIN_SER_CLK];
    die_oe[pbo_pkg::PIN_SER_DATA] = (ctrl.serial_start_interrupt_enable &
        ctrl.serial_pin_position_select) | pc_en[pbo_pkg::PIN_SER_DATA];
    die_ov[pbo_pkg::PIN_SER_DATA] = die_oe[pbo_pkg::PIN_SER_DATA];
    if (three_def) begin
      pv_oe[pbo_pkg::PIN_SER_DOUT] = 1'b1;
      pv_ov[pbo_pkg::PIN_SER_DOUT] = ctrl.serial_shift_out;
    end
    if (osc_two) begin
      {pu_oe[5], pu_ov[5], dd_oe[5], dd_ov[5], pv_oe[5], pv_ov[5]} = 6'h28;
    end
    if (osc_one) begin
      {pu_oe[4], pu_ov[4], dd_oe[4], dd_ov[4], pv_oe[4], pv_ov[4]} = 6'h28;
    end
    // clock out ignores port value and direction
    if (clk_out_on) begin
      dd_oe[pbo_pkg::PIN_CLK_OUT] = 1'b1;
      dd_ov[pbo_pkg::PIN_CLK_OUT] = 1'b1;
      pv_oe[pbo_pkg::PIN_CLK_OUT] = 1'b1;
      pv_ov[pbo_pkg::PIN_CLK_OUT] = ctrl.divided_clock_output;
    end
  end

  // ****************************************************************
  // per-pin merge with the port paths
  // ****************************************************************
  logic [6:0] dir_eff;
  logic [6:0] val_eff;
  logic [6:0] pull_eff;
  logic [6:0] die_eff;
  logic [6:0] din;

  genvar g;
  generate
    for (g = 0; g < pbo_pkg::NUM_PINS; g++) begin : g_pin
      assign dir_eff[g] = dd_oe[g] ? dd_ov[g] : direction_reg[g];
      assign val_eff[g] = pv_oe[g] ? pv_ov[g] : port_value_reg[g];
      // pull-up follows port value while input
      assign pull_eff[g] = pu_oe[g] ? pu_ov[g] :
          (~dir_eff[g] & port_value_reg[g] & ~ctrl.pullup_disable);
      assign die_eff[g] = die_oe[g] ? die_ov[g] : ~ctrl.sleep_input_gate;
      assign din[g] = pad_in[g] & die_eff[g];
    end
  endgenerate

  // ****************************************************************
  // pad and tap outputs
  // ****************************************************************
  // outputs are flopped so every port is clean; this adds one cycle of
  // latency against the peripheral, traded for glitch-free pads.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pad.pad_out <= {1'b0, clk_out_on & ctrl.divided_clock_output, 5'h00};
      pad.pad_oe_n <= {1'b1, ~clk_out_on, 5'h1f};
      pad.pad_pullup <= pbo_pkg::PIN_RESET_VAL;
      pad.toggle_request <= pbo_pkg::PIN_RESET_VAL;
      pad.input_enable <= pbo_pkg::PIN_RESET_VAL;
    end else begin
      // compare reaches pad only with direction out
      pad.pad_out <= val_eff & dir_eff;
      pad.pad_oe_n <= ~dir_eff;
      pad.pad_pullup <= pull_eff;
      pad.toggle_request <= tg_oe;
      pad.input_enable <= die_eff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      readback <= '0;
    end else begin
      readback.direction <= direction_reg;
      readback.port_value <= port_value_reg;
      readback.input_value <= din;
      if (osc_one) begin
        readback.direction[pbo_pkg::PIN_OSC_ONE] <= 1'b0;
        readback.port_value[pbo_pkg::PIN_OSC_ONE] <= 1'b0;
        readback.input_value[pbo_pkg::PIN_OSC_ONE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      external_interrupt_zero <= 1'b0;
      pin_change_source <= pbo_pkg::PIN_RESET_VAL;
      serial_clock_in <= 1'b0;
      serial_data_in <= 1'b0;
    end else begin
      external_interrupt_zero <= din[pbo_pkg::PIN_EXT_INT];
      pin_change_source <= din;
      serial_clock_in <= din[pbo_pkg::PIN_SER_CLK];
      // data input uses normal port path
      serial_data_in <= din[pbo_pkg::PIN_SER_DATA];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_compare_takeover: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.compare_a_output_enable & ctrl.timer1_output_select_control[6] &
     direction_reg[6]) |=> (pad.pad_out[6] == $past(ctrl.compare_a_wave)))
    else $error("pin 6 does not follow compare a");
  chk_ext_irq_buffer: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl.external_interrupt_zero_enable |=> pad.input_enable[6] &&
    (external_interrupt_zero == $past(pad_in[6])))
    else $error("external interrupt input buffer not forced on");
  chk_clock_out_pin: assert property (@(posedge sys_clk)
    ctrl.clock_output_fuse |=> !pad.pad_oe_n[5] &&
    pad.pad_out[5] == $past(ctrl.divided_clock_output))
    else $error("divided clock not on pin 5");
  chk_clock_in_reset: assert property (@(posedge sys_clk)
    (reset && ctrl.clock_output_fuse) |=> !pad.pad_oe_n[5])
    else $error("clock output dropped during reset");
  chk_osc_two_free: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.oscillator_pin_two_used && !ctrl.clock_output_fuse) |=>
    pad.pad_oe_n[5] && !pad.pad_pullup[5])
    else $error("pin 5 still used as io");
  chk_osc_one_read: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl.oscillator_pin_one_used |=> pad.pad_oe_n[4] &&
    readback.direction[4] == 1'b0 && readback.port_value[4] == 1'b0 &&
    readback.input_value[4] == 1'b0)
    else $error("pin 4 clock use not hidden");
  chk_three_wire_out: assert property (@(posedge sys_clk) disable iff (reset)
    (three_def && direction_reg[1]) |=> pad.pad_out[1] == $past(ctrl.serial_shift_out))
    else $error("three-wire data out not on pin 1");
  chk_three_wire_pull: assert property (@(posedge sys_clk) disable iff (reset)
    (three_def && !direction_reg[1] && port_value_reg[1] && !ctrl.pullup_disable)
    |=> pad.pad_pullup[1] && pad.pad_oe_n[1])
    else $error("pin 1 pull-up lost in three-wire mode");
  chk_two_wire_drain: assert property (@(posedge sys_clk) disable iff (reset)
    two_def |=> (pad.pad_oe_n[0] == !$past((ctrl.serial_shift_out |
    port_value_reg[0]) & direction_reg[0])) && !pad.pad_out[0])
    else $error("two-wire data pin not open-drain");
  chk_serial_toggle: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(ctrl.serial_toggle_override & ctrl.serial_pin_position_select) |=>
    pad.toggle_request[2] && pad.toggle_request[1:0] == 2'h0)
    else $error("toggle request not on pin 2");
  chk_pin_change_map: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.pin_change_group_enable && ctrl.pin_change_mask[3]) |=>
    pin_change_source[3] == $past(pad_in[3]))
    else $error("pin change source 11 mismatched");

  // ****************************************************************
  // further checks
  // ****************************************************************
  // these watch override terms on pins that the bench compares only in
  // some scenarios, so a broken term shows up wherever it is exercised.
  chk_osc_one_pins: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl.oscillator_pin_one_used |=> pad.pad_oe_n[4] && !pad.pad_pullup[4] &&
    !pad.pad_out[4])
    else $error("pin 4 still used as io");
  chk_pin4_input_on: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.pin_change_group_enable && ctrl.pin_change_mask[4]) |=> pad.input_enable[4])
    else $error("pin 4 input buffer not forced on");
  // an analog-disabled pin keeps its buffer off unless an interrupt needs it
  chk_pin5_analog_off: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.analog_input_disable[0] && !(ctrl.pin_change_group_enable &&
    ctrl.pin_change_mask[5])) |=> !pad.input_enable[5])
    else $error("pin 5 input buffer left on");
  chk_pin6_analog_off: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.analog_input_disable[1] && !ctrl.external_interrupt_zero_enable &&
    !(ctrl.pin_change_group_enable && ctrl.pin_change_mask[6])) |=> !pad.input_enable[6])
    else $error("pin 6 input buffer left on");
  chk_two_wire_clock: assert property (@(posedge sys_clk) disable iff (reset)
    two_def |=> (pad.pad_oe_n[2] == !$past((ctrl.serial_clock_hold |
    port_value_reg[2]) & direction_reg[2])) && !pad.pad_out[2])
    else $error("two-wire clock pin not open-drain");
  chk_serial_input_en: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.serial_start_interrupt_enable && ctrl.serial_pin_position_select) |=>
    pad.input_enable[2] && pad.input_enable[0])
    else $error("serial input buffers not forced on");
  chk_shift_priority: assert property (@(posedge sys_clk) disable iff (reset)
    (three_def && ctrl.compare_b_output_enable && ctrl.timer1_output_select_control[1])
    |=> pad.pad_out[1] == ($past(ctrl.serial_shift_out) & $past(direction_reg[1])))
    else $error("compare b beats serial shift-out on pin 1");
  // off the default position the serial block must leave pins 2 and 0 alone
  chk_alt_position: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl.serial_pin_position_select |=> pad.toggle_request == 7'h00 &&
    pad.pad_oe_n[2] == !$past(direction_reg[2]))
    else $error("serial override active off its default pins");
  chk_pin_change_order: assert property (@(posedge sys_clk) disable iff (reset)
    (ctrl.pin_change_group_enable && ctrl.pin_change_mask == 7'h7f) |=>
    pin_change_source == $past(pad_in))
    else $error("pin change sources not in pin order");
  // the clock pin is left out here: it keeps driving through reset
  chk_reset_quiet: assert property (@(posedge sys_clk)
    reset |=> pad.pad_pullup == 7'h00 && pad.toggle_request == 7'h00 &&
    pad.pad_oe_n[6] && pad.pad_oe_n[4:0] == 5'h1f)
    else $error("pins not released during reset");
  chk_merge_one_edge: assert property (@(posedge sys_clk) disable iff (reset)
    1'b1 |=> pad.pad_oe_n[3] == !$past(direction_reg[3]))
    else $error("pin 3 direction not merged in one edge");
  chk_readback_follow: assert property (@(posedge sys_clk) disable iff (reset)
    !ctrl.oscillator_pin_one_used |=> readback.direction == $past(direction_reg) &&
    readback.port_value == $past(port_value_reg))
    else $error("readback does not follow the port registers");

endmodule

`default_nettype wire

// ==== pbo_pkg.sv ====
// pbo_pkg: constants and carrier types for the port b alternate-function override block.
// assumes one i/o clock domain; every consumer uses the pbo_pkg:: prefix.
//
// Functional notes
// - compare waveform replaces value when enabled, selected
// - pin 6 external interrupt; input buffer forced on
// - fuse programmed: pin 5 drives divided clock
// - divided clock stays on pin 5 during reset
// - pin 5 oscillator use removes general-purpose io
// - pin 4 oscillator or clock input, no io
// - clocking pin 4 reads direction, value, input zero
// - three-wire data out replaces pin 1 value
// - pin 1 pull-up still follows port value
// - pins 6..4 no toggle override; pull/dir override only for clock use on 5, 4; pin4 input one
// - two-wire: open-drain direction overrides on pins 2, 0
// - pin 2 toggle, serial input enables, shift-out priority
// - pins 6..0 feed pin-change sources 14..8
package pbo_pkg;

  localparam int NUM_PINS = 7;
  localparam int PIN_EXT_INT = 6;
  localparam int PIN_CLK_OUT = 5;
  localparam int PIN_OSC_ONE = 4;
  localparam int PIN_SER_CLK = 2;
  localparam int PIN_SER_DOUT = 1;
  localparam int PIN_SER_DATA = 0;
  localparam int PCINT_BASE = 8;
  localparam logic [6:0] PIN_RESET_VAL = 7'h00;
  // compare a serves even pins, compare b odd pins
  localparam logic [6:0] COMPARE_A_PINS = 7'h55;

  typedef struct packed {
    logic compare_a_output_enable;
    logic compare_b_output_enable;
    logic compare_a_wave;
    logic compare_b_wave;
    logic [6:0] timer1_output_select_control; // per-pin select, bit n for pin n
    logic external_interrupt_zero_enable;
    logic pin_change_group_enable;
    logic [6:0] pin_change_mask;               // sources 14..8 on bits 6..0
    logic serial_two_wire_mode;
    logic serial_three_wire_mode;
    logic serial_pin_position_select;
    logic serial_clock_hold;
    logic serial_shift_out;
    logic serial_toggle_override;
    logic serial_start_interrupt_enable;
    logic [1:0] analog_input_disable;          // bit 1 pin 6, bit 0 pin 5
    logic clock_output_fuse;
    logic divided_clock_output;
    logic oscillator_pin_two_used;
    logic oscillator_pin_one_used;             // crystal or external clock input
    logic pullup_disable;
    logic sleep_input_gate;
  } pbo_ctrl_s;

  typedef struct packed {
    logic [6:0] pad_out;
    logic [6:0] pad_oe_n;
    logic [6:0] pad_pullup;
    logic [6:0] toggle_request;
    logic [6:0] input_enable;
  } pbo_pad_s;

  typedef struct packed {
    logic [6:0] direction;
    logic [6:0] port_value;
    logic [6:0] input_value;
  } pbo_read_s;

endpackage

// ==== tb_port_b_alt_function_override.sv ====
// tb_port_b_alt_function_override: self-checking bench for the port b override block.
// assumes pbo_pkg is compiled first and outputs lag their inputs by one sys_clk edge.
`timescale 1ns/10ps
`default_nettype none

module tb_port_b_alt_function_override;
  logic sys_clk, reset, slow;
  logic [6:0] port_value_reg, direction_reg, pad_in, pin_change_source;
  pbo_pkg::pbo_ctrl_s base, ctrl, ctrl_prev;
  pbo_pkg::pbo_pad_s pad;
  pbo_pkg::pbo_read_s readback;
  logic external_interrupt_zero, serial_clock_in, serial_data_in;
  logic wave_a, wave_b, div_clk, shift_out, clk_hold;
  integer seed, n_fail, num_checks, i, k;

  pbo_far_model pbo_far_model_inst (.sys_clk(sys_clk), .slow(slow), .wave_a(wave_a),
    .wave_b(wave_b), .div_clk(div_clk), .shift_out(shift_out), .clk_hold(clk_hold));

  pbo_override pbo_override_inst (.sys_clk(sys_clk), .reset(reset), .ctrl(ctrl),
    .port_value_reg(port_value_reg), .direction_reg(direction_reg), .pad_in(pad_in),
    .pad(pad), .readback(readback), .external_interrupt_zero(external_interrupt_zero),
    .pin_change_source(pin_change_source), .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in));

  // ****
  // far-side signals overlaid on the bench controls
  // ****
  always_comb begin
    ctrl = base;
    ctrl.compare_a_wave = wave_a;
    ctrl.compare_b_wave = wave_b;
    ctrl.divided_clock_output = div_clk;
    ctrl.serial_shift_out = shift_out;
    ctrl.serial_clock_hold = clk_hold;
  end

  // what the design sampled at the last edge
  always @(posedge sys_clk) ctrl_prev <= ctrl;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // expected pins for the compare scenario and the two-wire scenario
  function automatic logic [23:0] exp_compare(input pbo_pkg::pbo_ctrl_s p);
    return 24'({p.compare_a_wave, p.compare_b_wave, 5'h00});
  endfunction

  function automatic logic [23:0] exp_two_wire(input pbo_pkg::pbo_ctrl_s p,
    input logic [6:0] pin);
    return 24'({~p.serial_clock_hold, ~p.serial_shift_out, 2'b00, p.serial_toggle_override,
      2'b11, pin[2]});
  endfunction

  initial begin
    #100000;
    n_fail++;
    $display("ERROR watchdog expected end seen hang");
    finish_test();
  end

  // ****
  // main sequence
  // ****
  initial begin
    logic [63:0] r;
    pbo_pkg::pbo_ctrl_s c;
    logic [6:0] pv, dr, pi;
    seed = 74380;
    n_fail = 0;
    num_checks = 0;
    reset = 1'b1;
    slow = 1'b0;
    port_value_reg = 7'h7f;
    direction_reg = 7'h00;
    pad_in = 7'h00;
    base = '0;
    base.clock_output_fuse = 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      #1;
      r = {56'h0, pad.pad_oe_n[5], pad.pad_out[5], pad.pad_oe_n[6], pad.pad_oe_n[4:0]};
      check("reset pad", 24'({1'b0, ctrl_prev.divided_clock_output, 6'h3f}), r[23:0]);
    end
    @(posedge sys_clk);
    reset <= 1'b0;
    for (i = 0; i < 280; i++) begin
      k = i % 7;
      r = {$random(seed), $random(seed)};
      c = r[$bits(c)-1:0];
      r = {$random(seed), $random(seed)};
      pv = r[6:0];
      dr = r[13:7];
      pi = r[20:14];
      c.clock_output_fuse = (k == 2);
      c.oscillator_pin_one_used = (k == 3);
      c.oscillator_pin_two_used = (k == 3);
      c.serial_two_wire_mode = (k == 6);
      c.serial_three_wire_mode = (k == 4 || k == 5);
      c.serial_pin_position_select = (k >= 4) ? 1'b1 : c.serial_pin_position_select;
      c.compare_a_output_enable = 1'b1;
      c.compare_b_output_enable = 1'b1;
      c.timer1_output_select_control = 7'h7f;
      c.external_interrupt_zero_enable = (k == 1);
      c.pin_change_group_enable = (k == 1);
      c.pin_change_mask = 7'h7f;
      c.serial_start_interrupt_enable = (k == 6);
      c.pullup_disable = 1'b0;
      c.sleep_input_gate = (k == 5) ? 1'b0 : c.sleep_input_gate;
      // compare pins driven as outputs; pin 0 left input for serial data in
      case (k)
        0: dr = dr | 7'h48;
        3: begin pv[5:4] = 2'b11; dr[5:4] = 2'b11; pi[4] = 1'b1; end
        4: dr[1] = 1'b1;
        5: begin dr[1:0] = 2'b00; pv[1] = 1'b1; end
        6: begin dr[2] = 1'b1; dr[0] = 1'b1; pv[2] = 1'b0; pv[0] = 1'b0; end
        default: ;
      endcase
      @(posedge sys_clk);
      base <= c;
      port_value_reg <= pv;
      direction_reg <= dr;
      pad_in <= pi;
      slow <= r[21];
      @(posedge sys_clk);
      #1;
      c = ctrl_prev;
      case (k)
        0: check("cmp pins", exp_compare(c), 24'({pad.pad_out[6], pad.pad_out[3],
          pad.pad_oe_n[6], pad.pad_oe_n[3], pad.toggle_request[6:4]}));
        1: check("input en", 24'({1'b0, pi, 7'h7f, pi[6], pi}), 24'({1'b0, pin_change_source,
          pad.input_enable, external_interrupt_zero, readback.input_value}));
        2: check("clk out", 24'({1'b0, c.divided_clock_output}),
          24'({pad.pad_oe_n[5], pad.pad_out[5]}));
        3: check("osc pins", 24'h000018, 24'({pad.pad_oe_n[5:4], readback.direction[4],
          readback.port_value[4], readback.input_value[4]}));
        4: check("data out", 24'({c.serial_shift_out, 1'b0}),
          24'({pad.pad_out[1], pad.pad_oe_n[1]}));
        5: check("pull-up", 24'({2'b11, pi[0]}),
          24'({pad.pad_pullup[1], pad.pad_oe_n[1], serial_data_in}));
        default: check("two-wire", exp_two_wire(c, pi), 24'({pad.pad_oe_n[2], pad.pad_oe_n[0],
          pad.pad_out[2], pad.pad_out[0], pad.toggle_request[2], pad.input_enable[2],
          pad.input_enable[0], serial_clock_in}));
      endcase
      // outside oscillator use the readback mirrors the port registers
      if (k != 3) begin
        check("readback", 24'({dr, pv}),
          24'({readback.direction, readback.port_value}));
      end
    end
    finish_test();
  end
endmodule

`default_nettype wire
